// >>> rtl/urb_noise_filter.sv
`timescale 1ns/1ps
`default_nettype none
module urb_noise_filter (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sample_en,
  input  wire logic serial_rx_line,
  output var  logic filtered_rx
);
  import urb_pkg::*;

  logic meta_a;
  logic meta_b;
  logic meta_c;
  logic sync_lvl;
  logic samp_a;

  // Pin synchroniser; meta_a only feeds meta_b
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_a <= LINE_IDLE;
      meta_b <= LINE_IDLE;
      meta_c <= LINE_IDLE;
    end else begin
      meta_a <= serial_rx_line;
      meta_b <= meta_a;
      meta_c <= meta_b;
    end
  end

  // Level accepted once the last two stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_lvl <= LINE_IDLE;
    end else if (meta_b == meta_c) begin
      sync_lvl <= meta_c;
    end
  end

  // two tick lag
  // First tick latches, second tick passes on agreement
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_a      <= LINE_IDLE;
      filtered_rx <= LINE_IDLE;
    end else if (sample_en) begin
      samp_a <= sync_lvl;
      if (sync_lvl == samp_a) begin
        filtered_rx <= samp_a;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/urb_pkg.sv
package urb_pkg;

  // Register byte offsets on the 32-bit bus
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_BGC  = 5'h04;
  localparam logic [4:0] OFS_ERR  = 5'h08;
  localparam logic [4:0] OFS_RXB  = 5'h0C;
  localparam logic [4:0] OFS_TXS  = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;

  // Baud counter width and divisor limits
  localparam int         CNT_W   = 5;
  localparam logic [4:0] K_MIN   = 5'h08;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // Prescaler masks: tick when all masked bits are set
  localparam logic [4:0] PRE_DIV2  = 5'h01;
  localparam logic [4:0] PRE_DIV8  = 5'h07;
  localparam logic [4:0] PRE_DIV32 = 5'h1F;

  // Last data bit index for 7 and 8 bit characters
  localparam logic [2:0] LAST7 = 3'h6;
  localparam logic [2:0] LAST8 = 3'h7;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BGC_RST  = 8'h1F;
  localparam logic       LINE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } urb_par_t;

  typedef enum logic [1:0] {
    CS_TIMER = 2'h0,
    CS_DIV2  = 2'h1,
    CS_DIV8  = 2'h2,
    CS_DIV32 = 2'h3
  } urb_clk_t;

  // Gray coded along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_START = 3'h1,
    S_DATA  = 3'h3,
    S_PAR   = 3'h2,
    S_STOP  = 3'h6
  } urb_rx_state_t;

  typedef struct packed {
    logic     port_power_on;
    logic     tx_enable_bit;
    logic     rx_enable_bit;
    urb_par_t parity;
    logic     len8;
    logic     stop2;
    logic     rsvd;
  } urb_mode_t;

  typedef struct packed {
    urb_clk_t   clk_sel;
    logic       rsvd;
    logic [4:0] divisor_k;
  } urb_bgc_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       parity_fault_flag;
    logic       framing;
    logic       overrun_fault_flag;
  } urb_err_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic       busy;
    logic       full;
  } urb_stat_t;

endpackage

// >>> rtl/urb_top.sv
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Detect parity, framing, overrun; raise error request
// - Reading error status clears the flags that the read returned
// - Parity fault on mismatch with configured odd or even type; zero type not checked
// - Framing fault when stop bit low
// - Overrun when buffer still unread at frame end
// - Sample line on base clock, two matching
// - Receive path lags line by two ticks
// - Separate 5-bit transmit and receive counters
// - Base clock gated low while power off
// - Transmit counter held zero unless powered, enabled
// - Transmit write clears transmit counter
// - Receive counter held zero unless powered, enabled
// - Receive counter stops after frame until start
// - Select timer, div2, div8 or div32
// - Divisor k valid from 8 to 31
// - Bit rate is base clock over 2k
// - Falling edge starts count; low confirms start
// - Overrun character not copied to buffer
// - Parity fault completes frame before request
module urb_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic        eight_bit_timer_output,
  input  wire logic        serial_rx_line,
  output var  logic        base_clock_en,
  output var  logic        tx_half_tick,
  output var  logic        tx_load,
  output var  logic [7:0]  tx_data,
  output var  logic [7:0]  rx_buffer,
  output var  logic        rx_done_or_error_irq,
  output var  logic        rx_error_irq
);
  import urb_pkg::*;

  urb_mode_t       port_mode_register;
  urb_bgc_t        baud_generator_control;
  urb_err_t        rx_error_status;
  logic            buf_full;
  logic [4:0]      prescale;
  logic [4:0]      tx_cnt;
  logic [4:0]      rx_cnt;
  urb_rx_state_t   state;
  urb_rx_state_t   next_state;
  logic            filt;
  logic            filt_q;
  logic            phase;
  logic [2:0]      bit_idx;
  logic [7:0]      rx_shift_register;
  logic            par_bit;
  logic            full_seen;

  // Bus access decode
  wire        accept   = (read | write) & ~waitrequest;
  wire        wr_low   = accept & write & byteenable[0];
  wire        rd_acc   = accept & read;
  wire [4:0]  word_ofs = {address[4:2], 2'b00};
  wire        wr_mode  = wr_low & (word_ofs == OFS_MODE);
  wire        wr_bgc   = wr_low & (word_ofs == OFS_BGC);
  wire        wr_txs   = wr_low & (word_ofs == OFS_TXS);
  wire        rd_err   = rd_acc & (word_ofs == OFS_ERR);
  wire        rd_rxb   = rd_acc & (word_ofs == OFS_RXB);

  // Read mux; unmapped words read as zero
  urb_stat_t  stat_word;
  logic [7:0] rd_mux;
  assign stat_word = '{rsvd: '0, busy: (state != S_IDLE), full: buf_full};
  always_comb begin
    case (word_ofs)
      OFS_MODE: rd_mux = port_mode_register;
      OFS_BGC:  rd_mux = baud_generator_control;
      OFS_ERR:  rd_mux = rx_error_status;
      OFS_RXB:  rd_mux = rx_buffer;
      OFS_STAT: rd_mux = stat_word;
      default:  rd_mux = 8'h00;
    endcase
  end

  // One wait cycle per access; data registered as wait drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      full_seen   <= 1'b0;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if ((read | write) & waitrequest) begin
        readdata  <= {24'h00_0000, rd_mux};
        full_seen <= buf_full; // Buffer state behind the returned byte
      end
    end
  end

  // Software written control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_mode_register     <= MODE_RST;
      baud_generator_control <= BGC_RST;
    end else begin
      if (wr_mode) begin
        port_mode_register <= writedata[7:0];
      end
      if (wr_bgc) begin
        baud_generator_control <= writedata[7:0];
      end
    end
  end

  // Enables and divisor; out-of-range k is clamped to the minimum
  wire       power  = port_mode_register.port_power_on;
  wire       tx_on  = power & port_mode_register.tx_enable_bit;
  wire       rx_on  = power & port_mode_register.rx_enable_bit;
  wire [4:0] k_eff  = (baud_generator_control.divisor_k < K_MIN) ?
                      K_MIN : baud_generator_control.divisor_k;
  wire [4:0] k_last = k_eff - CNT_ONE;

  logic sel_tick;
  always_comb begin
    case (baud_generator_control.clk_sel)
      CS_TIMER: sel_tick = eight_bit_timer_output;
      CS_DIV2:  sel_tick = ((prescale & PRE_DIV2) == PRE_DIV2);
      CS_DIV8:  sel_tick = ((prescale & PRE_DIV8) == PRE_DIV8);
      CS_DIV32: sel_tick = ((prescale & PRE_DIV32) == PRE_DIV32);
      default:  sel_tick = 1'b0;
    endcase
  end

  // base clock gated by power
  // Prescaler held at zero so ticks restart in phase after power-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale      <= 5'h00;
      base_clock_en <= 1'b0;
    end else begin
      prescale      <= power ? prescale + CNT_ONE : 5'h00;
      base_clock_en <= power & sel_tick;
    end
  end

  wire tx_half = tx_on & base_clock_en & (tx_cnt == k_last);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt       <= 5'h00;
      tx_half_tick <= 1'b0;
    end else if (!tx_on || wr_txs) begin
      tx_cnt       <= 5'h00;
      tx_half_tick <= 1'b0;
    end else begin
      tx_half_tick <= tx_half;
      if (base_clock_en) begin
        tx_cnt <= tx_half ? 5'h00 : tx_cnt + CNT_ONE;
      end
    end
  end

  // Transmit character handed to the shift path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_load <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_load <= wr_txs & tx_on;
      if (wr_txs) begin
        tx_data <= writedata[7:0];
      end
    end
  end

  urb_noise_filter u_filter (
    .clk            (clk),
    .rst_b          (rst_b),
    .sample_en      (base_clock_en),
    .serial_rx_line (serial_rx_line),
    .filtered_rx    (filt)
  );

  // Receive timing: half-bit tick, sample on every second one
  wire rx_fall  = filt_q & ~filt;
  wire rx_half  = base_clock_en & (state != S_IDLE) & (rx_cnt == k_last);
  wire samp     = rx_half & phase;
  wire last_bit = bit_idx == (port_mode_register.len8 ? LAST8 : LAST7);
  wire par_on   = port_mode_register.parity != PAR_NONE;
  wire confirm  = (state == S_START) & rx_half & ~filt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt <= 5'h00;
    end else if (!rx_on || state == S_IDLE) begin
      rx_cnt <= 5'h00;
    end else if (base_clock_en) begin
      rx_cnt <= rx_half ? 5'h00 : rx_cnt + CNT_ONE;
    end
  end

  // Receive sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:  if (rx_fall) begin
        next_state = S_START;
      end
      S_START: if (rx_half) begin
        next_state = filt ? S_IDLE : S_DATA;
      end
      S_DATA:  if (samp && last_bit) begin
        next_state = par_on ? S_PAR : S_STOP;
      end
      S_PAR:   if (samp) begin
        next_state = S_STOP;
      end
      S_STOP:  if (samp) begin
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    if (!rx_on) begin
      next_state = S_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state  <= S_IDLE;
      filt_q <= LINE_IDLE;
    end else begin
      state  <= next_state;
      filt_q <= filt;
    end
  end

  // Bit capture, LSB first into the shift register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase             <= 1'b0;
      bit_idx           <= 3'h0;
      rx_shift_register <= 8'h00;
      par_bit           <= 1'b0;
    end else if (confirm) begin
      phase             <= 1'b0;
      bit_idx           <= 3'h0;
      rx_shift_register <= 8'h00;
    end else if (rx_half) begin
      phase <= ~phase;
      if (samp && state == S_DATA) begin
        rx_shift_register[bit_idx] <= filt;
        bit_idx                    <= bit_idx + 3'h1;
      end
      if (samp && state == S_PAR) begin
        par_bit <= filt;
      end
    end
  end

  // Fault evaluation at the stop bit sample
  wire      frame_done = (state == S_STOP) & samp;
  wire      ones_odd   = ^{rx_shift_register, par_bit};
  urb_err_t new_err;
  wire      par_fault  = ((port_mode_register.parity == PAR_ODD) & ~ones_odd) |
                         ((port_mode_register.parity == PAR_EVEN) & ones_odd);
  wire      stop_low   = ~filt;
  wire      ovr_hit    = buf_full;
  assign new_err = '{rsvd: 5'h00, parity_fault_flag: par_fault, framing: stop_low,
                     overrun_fault_flag: ovr_hit};

  // read clears flags
  // Only flags the read returned are cleared, so one set in the wait cycle survives
  wire [7:0] err_kept = rd_err ? (rx_error_status & ~readdata[7:0]) : rx_error_status;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_error_status <= 8'h00;
    end else begin
      rx_error_status <= err_kept | (frame_done ? new_err : 8'h00);
    end
  end

  // Full clears only when the read returned a full buffer; a fill in the wait cycle stays
  // no copy on overrun
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buffer <= 8'h00;
      buf_full  <= 1'b0;
    end else begin
      buf_full <= (buf_full & ~(rd_rxb & full_seen)) | (frame_done & ~buf_full);
      if (frame_done && !buf_full) begin
        rx_buffer <= rx_shift_register;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_done_or_error_irq <= 1'b0;
      rx_error_irq         <= 1'b0;
    end else begin
      rx_done_or_error_irq <= frame_done;
      rx_error_irq         <= frame_done & (|new_err);
    end
  end

endmodule
`default_nettype wire

// >>> testbench/uart_rx_error_and_baud_generator_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module uart_rx_error_and_baud_generator_bench;
  import urb_pkg::*;
  logic        clk, rst_b, read, write, eight_bit_timer_output, e;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic [7:0]  tx_data, rx_buffer, d, d2, q;
  logic        waitrequest, base_clock_en, tx_half_tick, tx_load;
  logic        rx_done_or_error_irq, rx_error_irq;
  wire logic   serial_rx_line;
  int          miscompares = 0, check_count = 0, cyc = 0, n, kind;
  urb_top u_dut (.clk, .rst_b, .address, .read, .write, .writedata, .byteenable(4'hF),
    .readdata, .waitrequest, .eight_bit_timer_output, .serial_rx_line, .base_clock_en,
    .tx_half_tick, .tx_load, .tx_data, .rx_buffer, .rx_done_or_error_irq, .rx_error_irq);
  urb_line_model u_line (.clk, .serial_rx_line);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Timer pulse every fourth cycle; watchdog ends a hung run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    eight_bit_timer_output <= (cyc % 4 == 0);
    if (cyc > 15000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // Ticks in 64 cycles per select code
  function automatic int base_count(input logic [1:0] s);
    return (s == 2'h0) ? 16 : (s == 2'h1) ? 32 : (s == 2'h2) ? 8 : 2;
  endfunction
  // Flags: parity bit 2, framing bit 1, overrun bit 0
  function automatic logic [7:0] err_exp(input int kd, input logic ovr);
    return {5'h00, kd == 1, kd == 2, ovr};
  endfunction
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h00_0000, v};
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    `CHK(q, x)
  endtask
  // Bit time is 2k base ticks: div2 and k = 8 give 32 cycles
  task automatic frame(input logic [7:0] v, input int kd, input logic x);
    fork
      u_line.send(v, 32, kd == 1, kd != 2);
      begin
        @(posedge clk);
        while (rx_done_or_error_irq !== 1'b1) @(posedge clk);
        e = rx_error_irq;
      end
    join
    `CHK(e, x)
  endtask
  task automatic count_base();
    repeat (8) @(posedge clk);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      n += int'(base_clock_en === 1'b1);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    eight_bit_timer_output = 1'b0;
    n = $urandom(26323);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped word
    rd_chk(OFS_MODE, 8'h00);
    rd_chk(OFS_BGC, 8'h1F);
    rd_chk(5'h18, 8'h00);
    // Every select code with the port powered
    bus(1'b1, OFS_MODE, 8'h80);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, OFS_BGC, {s[1:0], 6'h08});
      count_base();
      `CHK(n, base_count(s[1:0]))
    end
    bus(1'b1, OFS_MODE, 8'h00);
    count_base();
    `CHK(n, 0)
    // Power, both enables, even parity, 8 bits
    bus(1'b1, OFS_BGC, 8'h48);
    bus(1'b1, OFS_MODE, 8'hFC);
    // Clean, parity fault, framing fault, then a random mix
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      kind = (i < 3) ? i : int'($urandom_range(2, 0));
      frame(d, kind, kind != 0);
      rd_chk(OFS_ERR, err_exp(kind, 1'b0));
      rd_chk(OFS_ERR, 8'h00);
      rd_chk(OFS_RXB, d);
      `CHK(rx_buffer, d)
    end
    // Second character lands before the first is read
    d = 8'($urandom);
    d2 = 8'($urandom);
    frame(d, 0, 1'b0);
    frame(d2, 0, 1'b1);
    rd_chk(OFS_ERR, err_exp(0, 1'b1));
    rd_chk(OFS_RXB, d);
    `CHK(rx_buffer, d)
    bus(1'b1, OFS_TXS, d2);
    repeat (2) @(posedge clk);
    `CHK(tx_data, d2)
    // Odd type: the even-parity sender now faults, a flipped parity bit passes
    bus(1'b1, OFS_MODE, 8'hF4);
    d = 8'($urandom);
    frame(d, 0, 1'b1);
    rd_chk(OFS_ERR, err_exp(1, 1'b0));
    rd_chk(OFS_RXB, d);
    frame(d, 1, 1'b0);
    rd_chk(OFS_ERR, 8'h00);
    // Receiver disabled: a whole frame passes unseen
    bus(1'b1, OFS_MODE, 8'hC0);
    fork
      u_line.send(d, 32, 1'b0, 1'b1);
      begin
        n = 0;
        repeat (420) begin
          @(posedge clk);
          n += int'(rx_done_or_error_irq === 1'b1);
        end
      end
    join
    `CHK(n, 0)
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> testbench/urb_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module urb_line_model (
  input  wire logic clk,
  output var  logic serial_rx_line
);
  // Line rests high between frames
  initial serial_rx_line = 1'b1;
  // rate matches receiver
  // Start, 8 data LSB first, even parity, stop, then two idle bits
  task automatic send(input logic [7:0] d, input int bit_clks, input logic bad_par,
                      input logic stop_v);
    logic [10:0] f;
    f = {stop_v, ^d ^ bad_par, d, 1'b0};
    for (int b = 0; b < 13; b++) begin
      @(posedge clk);
      serial_rx_line <= (b < 11) ? f[b] : 1'b1;
      repeat (bit_clks - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/urb_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module urb_top_monitor
  import urb_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        eight_bit_timer_output,
  input wire logic        serial_rx_line,
  input wire logic        base_clock_en,
  input wire logic        tx_half_tick,
  input wire logic        tx_load,
  input wire logic [7:0]  tx_data,
  input wire logic [7:0]  rx_buffer,
  input wire logic        rx_done_or_error_irq,
  input wire logic        rx_error_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       pwr, txe, clean, full;
  logic [1:0] sel, arm;
  logic [4:0] k;
  logic [5:0] ticks;
  // Transfers take effect at the edge where waitrequest is low
  wire logic       wr_ok  = write && !waitrequest && byteenable[0];
  wire logic       rd_ok  = read && !waitrequest;
  wire logic [7:0] wd     = writedata[7:0];
  wire logic       tx_run = pwr && txe;
  // Shadow of the control bits, rebuilt from bus traffic alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {pwr, txe} <= 2'h0;
      {sel, k} <= 7'h1F;
    end else if (wr_ok && address == OFS_MODE) begin
      {pwr, txe} <= wd[7:6];
    end else if (wr_ok && address == OFS_BGC) begin
      {sel, k} <= {wd[7:6], wd[4:0]};
    end
  end
  // Ticks between half ticks; three half ticks after any write, as the first may be stale
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ticks <= 6'h00;
      arm <= 2'h0;
      clean <= 1'b1;
      full <= 1'b0;
    end else begin
      ticks <= tx_half_tick ? 6'h00 : ticks + 6'(base_clock_en);
      arm <= wr_ok ? 2'h0 : (tx_half_tick && arm != 2'h3) ? arm + 2'h1 : arm;
      clean <= rx_done_or_error_irq ? 1'b0 : (rd_ok && address == OFS_ERR) ? 1'b1 : clean;
      full <= rx_done_or_error_irq ? 1'b1 : (rd_ok && address == OFS_RXB) ? 1'b0 : full;
    end
  end
  sequence div2_gap;
    !base_clock_en ##1 base_clock_en;
  endsequence
  sequence tx_quiet;
    !tx_half_tick [*6];
  endsequence
  err_pulse_a: assert property (rx_error_irq |-> rx_done_or_error_irq)
    else $error("error request without completion");
  err_clear_a: assert property (rd_ok && address == OFS_ERR && clean |-> readdata == 32'h0)
    else $error("flags survived a read");
  err_bits_a: assert property (rd_ok && address == OFS_ERR |-> readdata[31:3] == 29'h0)
    else $error("unused flag bits set");
  base_gate_a: assert property (!pwr && !$past(pwr) |-> !base_clock_en)
    else $error("base tick while unpowered");
  div2_rate_a: assert property (base_clock_en && pwr && !write && sel == CS_DIV2 &&
    $past(sel) == CS_DIV2 |=> div2_gap) else $error("base tick spacing wrong");
  tx_idle_a: assert property (!tx_run && !$past(tx_run) |-> !tx_half_tick)
    else $error("half tick while disabled");
  half_span_a: assert property (tx_half_tick && arm == 2'h3 |->
    ticks + 6'(base_clock_en) == 6'(k)) else $error("half tick not k base ticks");
  tx_write_a: assert property (wr_ok && address == OFS_TXS && tx_run |=>
    tx_load && tx_data == $past(wd) ##1 tx_quiet) else $error("transmit write not aligned");
  overrun_a: assert property (rx_done_or_error_irq && full |->
    rx_error_irq && $stable(rx_buffer)) else $error("overrun not handled");
endmodule
bind urb_top urb_top_monitor u_mon (.clk, .rst_b, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .eight_bit_timer_output, .serial_rx_line,
  .base_clock_en, .tx_half_tick, .tx_load, .tx_data, .rx_buffer, .rx_done_or_error_irq,
  .rx_error_irq);
`default_nettype wire
